// ==== core/dtc_pkg.sv ====
// dtc_pkg: shared constants and types of the dual timer/counter block
package dtc_pkg;

  // ----------------------------------------------------------------
  // register addresses on the special-function-register bus
  // ----------------------------------------------------------------
  localparam logic [7:0] DTC_ADDR_MODE_CTRL = 8'h89;
  localparam logic [7:0] DTC_ADDR_T0_LOW = 8'h8a;
  localparam logic [7:0] DTC_ADDR_T1_LOW = 8'h8b;
  localparam logic [7:0] DTC_ADDR_T0_HIGH = 8'h8c;
  localparam logic [7:0] DTC_ADDR_T1_HIGH = 8'h8d;
  localparam logic [7:0] DTC_ADDR_CLOCK_CTRL = 8'h8e;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DTC_T1_GATE_BIT = 7;
  localparam int DTC_T1_CT_BIT = 6;
  localparam int DTC_T1_MODE_LSB = 4;
  localparam int DTC_T0_GATE_BIT = 3;
  localparam int DTC_T0_CT_BIT = 2;
  localparam int DTC_T0_MODE_LSB = 0;
  localparam int DTC_T1_FAST_BIT = 4;
  localparam int DTC_T0_FAST_BIT = 3;
  localparam int DTC_M13_LOW_BITS = 5;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] DTC_MODE_CTRL_RESET = 8'h00;
  localparam logic [7:0] DTC_COUNT_RESET = 8'h00;
  localparam logic [7:0] DTC_CLOCK_CTRL_RESET = 8'h01;
  localparam logic [7:0] DTC_RDATA_RESET = 8'h00;

  // ----------------------------------------------------------------
  // prescaler divide ratios, in system clock cycles per tick
  // ----------------------------------------------------------------
  localparam logic [3:0] DTC_DIV_SLOW = 4'hc;
  localparam logic [3:0] DTC_DIV_FAST = 4'h4;
  localparam logic [3:0] DTC_PRE_RESET = 4'h0;

  // ----------------------------------------------------------------
  // operating modes of one timer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DTC_MODE_13BIT = 2'b00,
    DTC_MODE_16BIT = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT = 2'b11
  } dtc_mode_t;

endpackage : dtc_pkg

// ==== core/dtc_pin_sync.sv ====
// dtc_pin_sync: synchronisers and falling-edge detection for the timer pins
`timescale 1ns/100ps
module dtc_pin_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] pins_raw,
  output logic [3:0] pins_level,
  output logic [3:0] pins_fall
);

  logic [3:0] meta_q;
  logic [3:0] meta_d;
  logic [3:0] sync_q;
  logic [3:0] sync_d;
  logic [3:0] last_q;
  logic [3:0] last_d;

  // ----------------------------------------------------------------
  // two-flop synchroniser plus a history stage, one per pin
  // ----------------------------------------------------------------
  // the edge detector looks only at the second and third stages so a
  // metastable first stage never reaches counting logic
  genvar g;
  for (g = 0; g < 4; g++) begin : g_pin
    always_comb begin
      meta_d[g] = pins_raw[g];
      sync_d[g] = meta_q[g];
      last_d[g] = sync_q[g];
    end
    assign pins_level[g] = sync_q[g];
    assign pins_fall[g] = last_q[g] & ~sync_q[g];
  end

  // registers, pins idle high after reset so no false edge appears
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= 4'hf;
      sync_q <= 4'hf;
      last_q <= 4'hf;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

endmodule : dtc_pin_sync

// ==== core/dtc_prescale.sv ====
// dtc_prescale: divide-by-12 or divide-by-4 tick generator for one timer
`timescale 1ns/100ps
module dtc_prescale (
  input wire logic mclk,
  input wire logic rst,
  input wire logic fast,
  output logic tick
);

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic tick_q;
  logic tick_d;
  logic [3:0] last_cnt;

  // ----------------------------------------------------------------
  // free-running divider
  // ----------------------------------------------------------------
  // the ratio switches on the fly; a count already past the new limit
  // wraps at once rather than running up to sixteen
  always_comb begin
    last_cnt = fast ? (dtc_pkg::DTC_DIV_FAST - 4'h1) : (dtc_pkg::DTC_DIV_SLOW - 4'h1);
    tick_d = (cnt_q >= last_cnt);
    cnt_d = tick_d ? dtc_pkg::DTC_PRE_RESET : cnt_q + 4'h1;
  end

  // registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= dtc_pkg::DTC_PRE_RESET;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : dtc_prescale

// ==== core/dtc_timer_top.sv ====
// dtc_timer_top: two timer/counters with mode, count and clock control registers
`timescale 1ns/100ps
module dtc_timer_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic timer0_run,
  input wire logic timer1_run,
  input wire logic timer0_flag_clr,
  input wire logic timer1_flag_clr,
  input wire logic timer0_int_ack,
  input wire logic timer1_int_ack,
  input wire logic ext_gate0_n,
  input wire logic ext_gate1_n,
  input wire logic count_in0,
  input wire logic count_in1,
  output logic timer0_overflow_flag,
  output logic timer1_overflow_flag
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] timer_mode_ctrl_q;
  logic [7:0] timer_mode_ctrl_d;
  logic [7:0] clock_ctrl_q;
  logic [7:0] clock_ctrl_d;
  logic [7:0] timer0_count_low_q;
  logic [7:0] timer0_count_low_d;
  logic [7:0] timer0_count_high_q;
  logic [7:0] timer0_count_high_d;
  logic [7:0] timer1_count_low_q;
  logic [7:0] timer1_count_low_d;
  logic [7:0] timer1_count_high_q;
  logic [7:0] timer1_count_high_d;
  logic timer0_overflow_flag_q;
  logic timer0_overflow_flag_d;
  logic timer1_overflow_flag_q;
  logic timer1_overflow_flag_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // ----------------------------------------------------------------
  // decoded controls and count events
  // ----------------------------------------------------------------
  logic [3:0] pins_level;
  logic [3:0] pins_fall;
  logic gate0_level;
  logic gate1_level;
  logic tick0;
  logic tick1;
  logic src0;
  logic src1;
  logic enable0;
  logic enable1;
  logic inc0;
  logic inc1;
  logic inc0_high;
  logic split0;
  dtc_pkg::dtc_mode_t mode0;
  dtc_pkg::dtc_mode_t mode1;
  logic [16:0] step0;
  logic [16:0] step1;
  logic [8:0] split_low_sum;
  logic [8:0] split_high_sum;
  logic set0;
  logic set1;
  logic wr_mode;
  logic wr_clock;
  logic wr_t0_low;
  logic wr_t0_high;
  logic wr_t1_low;
  logic wr_t1_high;

  // ----------------------------------------------------------------
  // one increment step for modes 00, 01 and 10
  // ----------------------------------------------------------------
  // result is {overflow, high byte, low byte}; split mode is handled by
  // the caller, so here it simply returns the count unchanged
  function automatic logic [16:0] dtc_step(
    input logic [1:0] mode,
    input logic [7:0] low,
    input logic [7:0] high
  );
    logic [13:0] sum13;
    logic [16:0] sum16;
    logic [8:0] sum8;
    logic [16:0] result;
    sum13 = {1'b0, high, low[4:0]} + 14'h0001;
    sum16 = {1'b0, high, low} + 17'h0_0001;
    sum8 = {1'b0, low} + 9'h001;
    case (mode)
      dtc_pkg::DTC_MODE_13BIT: begin
        // upper three bits of the low byte are not part of the count
        result = {sum13[13], sum13[12:dtc_pkg::DTC_M13_LOW_BITS], low[7:5],
                  sum13[dtc_pkg::DTC_M13_LOW_BITS-1:0]};
      end
      dtc_pkg::DTC_MODE_16BIT: begin
        result = sum16;
      end
      dtc_pkg::DTC_MODE_RELOAD: begin
        result = {sum8[8], high, sum8[8] ? high : sum8[7:0]};
      end
      default: begin
        result = {1'b0, high, low};
      end
    endcase
    return result;
  endfunction : dtc_step

  // ----------------------------------------------------------------
  // pin synchronisers and prescalers
  // ----------------------------------------------------------------
  dtc_pin_sync u_pin_sync (
    .mclk(mclk),
    .rst(rst),
    .pins_raw({count_in1, count_in0, ext_gate1_n, ext_gate0_n}),
    .pins_level(pins_level),
    .pins_fall(pins_fall)
  );

  dtc_prescale u_prescale0 (
    .mclk(mclk),
    .rst(rst),
    .fast(clock_ctrl_q[dtc_pkg::DTC_T0_FAST_BIT]),
    .tick(tick0)
  );

  // the divider sits beside the timer only, so the cpu cycle is unaffected
  dtc_prescale u_prescale1 (
    .mclk(mclk),
    .rst(rst),
    .fast(clock_ctrl_q[dtc_pkg::DTC_T1_FAST_BIT]),
    .tick(tick1)
  );

  // ----------------------------------------------------------------
  // count qualification
  // ----------------------------------------------------------------
  always_comb begin
    mode0 = dtc_pkg::dtc_mode_t'(timer_mode_ctrl_q[dtc_pkg::DTC_T0_MODE_LSB +: 2]);
    mode1 = dtc_pkg::dtc_mode_t'(timer_mode_ctrl_q[dtc_pkg::DTC_T1_MODE_LSB +: 2]);
    split0 = (mode0 == dtc_pkg::DTC_MODE_SPLIT);
    gate0_level = pins_level[0];
    gate1_level = pins_level[1];
    // count source: prescaled tick or synchronised falling edge of the pin
    src0 = timer_mode_ctrl_q[dtc_pkg::DTC_T0_CT_BIT] ? pins_fall[2] : tick0;
    src1 = timer_mode_ctrl_q[dtc_pkg::DTC_T1_CT_BIT] ? pins_fall[3] : tick1;
    enable0 = timer0_run & (~timer_mode_ctrl_q[dtc_pkg::DTC_T0_GATE_BIT] | gate0_level);
    // while timer 0 is split, timer 1 loses its run bit and runs on gate and mode alone
    enable1 = (split0 | timer1_run)
              & (~timer_mode_ctrl_q[dtc_pkg::DTC_T1_GATE_BIT] | gate1_level);
    inc0 = src0 & enable0;
    inc1 = src1 & enable1 & (mode1 != dtc_pkg::DTC_MODE_SPLIT);
    // split high byte: internal ticks only, started by timer 1 run
    inc0_high = split0 & tick0 & timer1_run;
  end

  // ----------------------------------------------------------------
  // bus write decode
  // ----------------------------------------------------------------
  always_comb begin
    wr_mode = sfr_wr & (sfr_addr == dtc_pkg::DTC_ADDR_MODE_CTRL);
    wr_clock = sfr_wr & (sfr_addr == dtc_pkg::DTC_ADDR_CLOCK_CTRL);
    wr_t0_low = sfr_wr & (sfr_addr == dtc_pkg::DTC_ADDR_T0_LOW);
    wr_t0_high = sfr_wr & (sfr_addr == dtc_pkg::DTC_ADDR_T0_HIGH);
    wr_t1_low = sfr_wr & (sfr_addr == dtc_pkg::DTC_ADDR_T1_LOW);
    wr_t1_high = sfr_wr & (sfr_addr == dtc_pkg::DTC_ADDR_T1_HIGH);
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // both bytes are plain read/write; every bit of the mode byte and the two
  // prescale bits act here, the other clock bits are kept for software
  always_comb begin
    timer_mode_ctrl_d = wr_mode ? sfr_wdata : timer_mode_ctrl_q;
    clock_ctrl_d = wr_clock ? sfr_wdata : clock_ctrl_q;
  end

  // control registers, mode cleared and the clock byte at its default
  always_ff @(posedge mclk) begin
    if (rst) begin
      timer_mode_ctrl_q <= dtc_pkg::DTC_MODE_CTRL_RESET;
      clock_ctrl_q <= dtc_pkg::DTC_CLOCK_CTRL_RESET;
    end else begin
      timer_mode_ctrl_q <= timer_mode_ctrl_d;
      clock_ctrl_q <= clock_ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // next state of counts and overflow events
  // ----------------------------------------------------------------
  // a software write to a count byte beats the increment of that cycle;
  // the other byte still steps, which matches a cpu writing bytes singly
  always_comb begin
    step0 = dtc_step(mode0, timer0_count_low_q, timer0_count_high_q);
    step1 = dtc_step(mode1, timer1_count_low_q, timer1_count_high_q);
    split_low_sum = {1'b0, timer0_count_low_q} + 9'h001;
    split_high_sum = {1'b0, timer0_count_high_q} + 9'h001;
    timer0_count_low_d = timer0_count_low_q;
    timer0_count_high_d = timer0_count_high_q;
    timer1_count_low_d = timer1_count_low_q;
    timer1_count_high_d = timer1_count_high_q;
    set0 = 1'b0;
    set1 = 1'b0;
    // timer 0
    if (split0) begin
      if (inc0) begin
        timer0_count_low_d = split_low_sum[7:0];
        set0 = split_low_sum[8];
      end
      if (inc0_high) begin
        timer0_count_high_d = split_high_sum[7:0];
        set1 = split_high_sum[8];
      end
    end else if (inc0) begin
      timer0_count_low_d = step0[7:0];
      timer0_count_high_d = step0[15:8];
      set0 = step0[16];
    end
    // timer 1; its flag belongs to the split high byte while timer 0 is split
    if (inc1) begin
      timer1_count_low_d = step1[7:0];
      timer1_count_high_d = step1[15:8];
      if (!split0) begin
        set1 = step1[16];
      end
    end
    // software access to the count bytes
    if (wr_t0_low) begin
      timer0_count_low_d = sfr_wdata;
    end
    if (wr_t0_high) begin
      timer0_count_high_d = sfr_wdata;
    end
    if (wr_t1_low) begin
      timer1_count_low_d = sfr_wdata;
    end
    if (wr_t1_high) begin
      timer1_count_high_d = sfr_wdata;
    end
  end

  // ----------------------------------------------------------------
  // overflow flags
  // ----------------------------------------------------------------
  // a set in the clearing cycle is kept, so an overflow is never lost;
  // in split mode the timer 1 flag belongs to the high byte of timer 0
  always_comb begin
    timer0_overflow_flag_d = set0 |
      (timer0_overflow_flag_q & ~(timer0_flag_clr | timer0_int_ack));
    timer1_overflow_flag_d = set1 |
      (timer1_overflow_flag_q & ~(timer1_flag_clr | timer1_int_ack));
  end

  // flag registers, cleared by reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      timer0_overflow_flag_q <= 1'b0;
      timer1_overflow_flag_q <= 1'b0;
    end else begin
      timer0_overflow_flag_q <= timer0_overflow_flag_d;
      timer1_overflow_flag_q <= timer1_overflow_flag_d;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // read data is registered, so it lags the address by one clock
  always_comb begin
    sfr_hit = 1'b1;
    unique case (sfr_addr)
      dtc_pkg::DTC_ADDR_MODE_CTRL: rdata_d = timer_mode_ctrl_q;
      dtc_pkg::DTC_ADDR_T0_LOW: rdata_d = timer0_count_low_q;
      dtc_pkg::DTC_ADDR_T1_LOW: rdata_d = timer1_count_low_q;
      dtc_pkg::DTC_ADDR_T0_HIGH: rdata_d = timer0_count_high_q;
      dtc_pkg::DTC_ADDR_T1_HIGH: rdata_d = timer1_count_high_q;
      dtc_pkg::DTC_ADDR_CLOCK_CTRL: rdata_d = clock_ctrl_q;
      default: begin
        rdata_d = dtc_pkg::DTC_RDATA_RESET;
        sfr_hit = 1'b0;
      end
    endcase
  end

  // read data register; unmapped places read as zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= dtc_pkg::DTC_RDATA_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // count registers
  // ----------------------------------------------------------------
  // the four count bytes reset to zero and otherwise take the next
  // values worked out above on every clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      timer0_count_low_q <= dtc_pkg::DTC_COUNT_RESET;
      timer0_count_high_q <= dtc_pkg::DTC_COUNT_RESET;
      timer1_count_low_q <= dtc_pkg::DTC_COUNT_RESET;
      timer1_count_high_q <= dtc_pkg::DTC_COUNT_RESET;
    end else begin
      timer0_count_low_q <= timer0_count_low_d;
      timer0_count_high_q <= timer0_count_high_d;
      timer1_count_low_q <= timer1_count_low_d;
      timer1_count_high_q <= timer1_count_high_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sfr_rdata = rdata_q;
  assign timer0_overflow_flag = timer0_overflow_flag_q;
  assign timer1_overflow_flag = timer1_overflow_flag_q;

endmodule : dtc_timer_top

// ==== verification/dtc_timer_asserts.sv ====
// dtc_timer_asserts: port-level checker for the dual timer/counter
`timescale 1ns/100ps
module dtc_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire logic timer0_run,
  input wire logic timer1_run,
  input wire logic timer0_flag_clr,
  input wire logic timer1_flag_clr,
  input wire logic timer0_int_ack,
  input wire logic timer1_int_ack,
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow_flag
);
  // ----------------------------------------------------------------
  // one clock domain, reset disables everything but the reset check
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // register window decode and read path
  a_hit_decode: assert property (sfr_hit == (sfr_addr >= 8'h89 && sfr_addr <= 8'h8e))
    else $error("hit does not match the register window");
  a_unmapped_zero: assert property (!sfr_hit |=> sfr_rdata == 8'h00)
    else $error("unmapped read is not zero");
  a_reset_rdata: assert property (disable iff (1'b0) rst |=> sfr_rdata == 8'h00)
    else $error("read data not zero after reset");

  // flags are sticky until a clear or an acknowledge
  a_flag0_sticky: assert property (timer0_overflow_flag && !timer0_flag_clr
    && !timer0_int_ack |=> timer0_overflow_flag)
    else $error("timer 0 flag dropped by itself");
  a_flag1_sticky: assert property (timer1_overflow_flag && !timer1_flag_clr
    && !timer1_int_ack |=> timer1_overflow_flag)
    else $error("timer 1 flag dropped by itself");

  // a clear while the timer is halted always wins
  a_flag0_clear: assert property (!timer0_run [*3] ##0
    (timer0_flag_clr || timer0_int_ack) |=> !timer0_overflow_flag)
    else $error("timer 0 flag not cleared");
  a_flag1_clear: assert property (!timer1_run [*3] ##0
    (timer1_flag_clr || timer1_int_ack) |=> !timer1_overflow_flag)
    else $error("timer 1 flag not cleared");

  // an overflow needs the run bit that owns the flag
  a_flag0_cause: assert property ($rose(timer0_overflow_flag)
    |-> $past(timer0_run) || $past(timer0_run, 2))
    else $error("timer 0 flag set while halted");
  a_flag1_cause: assert property ($rose(timer1_overflow_flag)
    |-> $past(timer1_run) || $past(timer1_run, 2))
    else $error("timer 1 flag set while halted");
endmodule : dtc_checker

bind dtc_timer_top dtc_checker u_chk (.mclk, .rst, .sfr_addr, .sfr_rdata, .sfr_hit,
  .timer0_run, .timer1_run, .timer0_flag_clr, .timer1_flag_clr, .timer0_int_ack,
  .timer1_int_ack, .timer0_overflow_flag, .timer1_overflow_flag);

// ==== verification/dtc_pin_model.sv ====
// dtc_pin_model: external gate and count pins driven at the far side
`timescale 1ns/100ps
module dtc_pin_model (
  input wire logic mclk,
  output logic count_in0,
  output logic count_in1,
  output logic ext_gate0_n,
  output logic ext_gate1_n
);
  logic [1:0] cnt_q = 2'b11;
  logic [1:0] gate_q = 2'b11;

  // pins idle high, so no falling edge appears at start
  assign count_in0 = cnt_q[0];
  assign count_in1 = cnt_q[1];
  assign ext_gate0_n = gate_q[0];
  assign ext_gate1_n = gate_q[1];

  // low and high phases of 3 cycles outlast the two-stage synchroniser
  task automatic pulse(input int t, input int n);
    repeat (n) begin
      @(posedge mclk);
      cnt_q[t] <= 1'b0;
      repeat (3) @(posedge mclk);
      cnt_q[t] <= 1'b1;
      repeat (2) @(posedge mclk);
    end
  endtask : pulse

  // gate level is a plain level, held until changed
  task automatic set_gate(input int t, input logic v);
    @(posedge mclk);
    gate_q[t] <= v;
  endtask : set_gate
endmodule : dtc_pin_model

// ==== verification/dtc_timer_top_tb_top.sv ====
// dtc_timer_top_tb_top: register-level testbench for the dual timer/counter
`timescale 1ns/100ps
module dtc_timer_top_tb_top;
  localparam logic [7:0] MODE = dtc_pkg::DTC_ADDR_MODE_CTRL;
  localparam logic [7:0] CKC = dtc_pkg::DTC_ADDR_CLOCK_CTRL;
  localparam logic [7:0] TL = dtc_pkg::DTC_ADDR_T0_LOW;
  localparam logic [7:0] TH = dtc_pkg::DTC_ADDR_T0_HIGH;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  logic [1:0] run = 2'b00;
  logic [1:0] clr = 2'b00;
  logic [1:0] ack = 2'b00;
  logic [1:0] flag;
  logic [1:0] cnt;
  logic [1:0] gate_n;
  int n_fail = 0;
  int check_count = 0;

  // 100 MHz clock
  always #5 mclk = ~mclk;

  dtc_pin_model PINS (.mclk(mclk), .count_in0(cnt[0]), .count_in1(cnt[1]),
    .ext_gate0_n(gate_n[0]), .ext_gate1_n(gate_n[1]));

  dtc_timer_top DUT (.mclk(mclk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .timer0_run(run[0]), .timer1_run(run[1]), .timer0_flag_clr(clr[0]),
    .timer1_flag_clr(clr[1]), .timer0_int_ack(ack[0]), .timer1_int_ack(ack[1]),
    .ext_gate0_n(gate_n[0]), .ext_gate1_n(gate_n[1]), .count_in0(cnt[0]),
    .count_in1(cnt[1]), .timer0_overflow_flag(flag[0]), .timer1_overflow_flag(flag[1]));

  // ----------------------------------------------------------------
  // verdict, comparison and bus tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one-cycle write strobe, data valid with it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge mclk);
    sfr_wr <= 1'b0;
  endtask : wr

  // read data lags the address by one registered cycle
  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    sfr_addr <= a;
    repeat (2) @(posedge mclk);
    chk(what, exp, sfr_rdata);
  endtask : rdchk

  // bounded wait; flag is read before the edge's updates land
  task automatic wait_flag(input int t, input int lo, output int n);
    n = 0;
    while (!(flag[t] === 1'b1 && n >= lo)) begin
      @(posedge mclk);
      n++;
      if (n > 400) begin
        n_fail++;
        tally_and_finish();
      end
    end
  endtask : wait_flag

  // set-to-set spacing, first gap by clear, second by acknowledge
  task automatic period(input int t, input int exp);
    int n;
    wait_flag(t, 0, n);
    for (int i = 0; i < 2; i++) begin
      if (i == 0) clr[t] <= 1'b1;
      else ack[t] <= 1'b1;
      @(posedge mclk);
      clr[t] <= 1'b0;
      ack[t] <= 1'b0;
      wait_flag(t, 1, n);
    end
    chk("tick spacing", 8'(exp), 8'(n));
  endtask : period

  // halt, then clear the flag and confirm it stays low
  task automatic quiet_clear(input int t);
    run[t] <= 1'b0;
    repeat (4) @(posedge mclk);
    clr[t] <= 1'b1;
    ack[t] <= 1'b1;
    @(posedge mclk);
    clr[t] <= 1'b0;
    ack[t] <= 1'b0;
    @(posedge mclk);
    chk("flag cleared", 8'h00, {7'h00, flag[t]});
  endtask : quiet_clear

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    // reset values, unmapped places, then two patterns through every byte
    for (int i = 0; i < 6; i++) rdchk("reset", 8'(MODE + i), (i == 5) ? 8'h01 : 8'h00);
    wr(8'h8f, 8'hff);
    rdchk("unmapped", 8'h8f, 8'h00);
    rdchk("unmapped", 8'h88, 8'h00);
    for (int j = 0; j < 2; j++)
      for (int i = 0; i < 6; i++) begin
        wr(8'(MODE + i), j ? 8'h5a : 8'ha5);
        rdchk("rw", 8'(MODE + i), j ? 8'h5a : 8'ha5);
      end
    // auto-reload at every tick measures both prescale ratios per timer
    for (int t = 0; t < 2; t++)
      for (int f = 0; f < 2; f++) begin
        wr(CKC, 8'h01 | (8'(f) << (3 + t)));
        wr(MODE, 8'(8'h02 << (4 * t)));
        wr(8'(TH + t), 8'hff);
        wr(8'(TL + t), 8'hff);
        run[t] <= 1'b1;
        period(t, f ? 3 : 11);
        run[t] <= 1'b0;
        rdchk("reload source", 8'(TH + t), 8'hff);
        quiet_clear(t);
      end
    // 13-bit and 16-bit wrap of timer 0
    for (int m = 0; m < 2; m++) begin
      wr(CKC, 8'h09);
      wr(MODE, 8'(m));
      wr(TH, 8'hff);
      wr(TL, 8'hff);
      run[0] <= 1'b1;
      wait_flag(0, 0, n);
      run[0] <= 1'b0;
      rdchk("wrap low", TL, m ? 8'h00 : 8'he0);
      rdchk("wrap high", TH, 8'h00);
      quiet_clear(0);
    end
    // gate closed holds the count, gate open lets it overflow
    wr(CKC, 8'h19);
    for (int t = 0; t < 2; t++) begin
      wr(MODE, 8'(8'h0a << (4 * t)));
      wr(8'(TH + t), 8'hff);
      wr(8'(TL + t), 8'hff);
      PINS.set_gate(t, 1'b0);
      repeat (4) @(posedge mclk);
      run[t] <= 1'b1;
      repeat (40) @(posedge mclk);
      chk("gated flag", 8'h00, {7'h00, flag[t]});
      PINS.set_gate(t, 1'b1);
      wait_flag(t, 0, n);
      quiet_clear(t);
    end
    // counter operation counts pin falls only
    for (int t = 0; t < 2; t++) begin
      wr(MODE, 8'(8'h05 << (4 * t)));
      wr(8'(TL + t), 8'h00);
      run[t] <= 1'b1;
      PINS.pulse(t, 5);
      repeat (4) @(posedge mclk);
      run[t] <= 1'b0;
      rdchk("pin count", 8'(TL + t), 8'h05);
    end
    // timer 1 mode 11 keeps its count
    wr(MODE, 8'h30);
    wr(8'(TL + 1), 8'h10);
    run[1] <= 1'b1;
    repeat (40) @(posedge mclk);
    rdchk("halted count", 8'(TL + 1), 8'h10);
    run[1] <= 1'b0;
    // split mode: high byte on timer 1 run, timer 1 free of its run bit
    wr(MODE, 8'h13);
    wr(TL, 8'hff);
    wr(TH, 8'hff);
    wr(8'(TL + 1), 8'h00);
    run[1] <= 1'b1;
    wait_flag(1, 0, n);
    run[1] <= 1'b0;
    rdchk("split high", TH, 8'h00);
    rdchk("split low idle", TL, 8'hff);
    // timer 1 must keep counting now that its run bit is low
    wr(8'(TL + 1), 8'h00);
    repeat (8) @(posedge mclk);
    sfr_addr <= 8'(TL + 1);
    repeat (2) @(posedge mclk);
    chk("split timer 1 runs", 8'h01, {7'h00, sfr_rdata > 8'h00});
    quiet_clear(1);
    run[0] <= 1'b1;
    wait_flag(0, 0, n);
    quiet_clear(0);
    tally_and_finish();
  end
endmodule : dtc_timer_top_tb_top
